// ---- rtl/bdw_regs.vh ----
// constants of the button decoder and converter writer
`ifndef BDW_REGS_VH
`define BDW_REGS_VH
// ==========================================
// register byte offsets
`define BDW_OFS_CTRL 5'h00
`define BDW_OFS_SAMPLE 5'h04
`define BDW_OFS_BUTTON 5'h08
`define BDW_OFS_DISP 5'h0C
`define BDW_OFS_IRQ_STATUS 5'h10
`define BDW_OFS_IRQ_ENABLE 5'h14
`define BDW_OFS_IRQ_CLEAR 5'h18
// ==========================================
// field positions
`define BDW_CTRL_MONITOR 0
`define BDW_DISP_NEWREF 8
`define BDW_EV_CHANGE 0
`define BDW_EV_PRESS 1
`define BDW_EV_DACDONE 2
`define BDW_EV_REFUSED 3
`define BDW_EV_TXDONE 4
`define BDW_EV_W 5
// ==========================================
// reset values and word framing
`define BDW_LINES_IDLE 4'hF
`define BDW_DAC_CTRL_BITS 3'h0
`define BDW_DAC_FILL_BITS 3'h0
`define BDW_DAC_LAST_BIT 4'hF
`define BDW_UART_LAST_BIT 4'h9
// ==========================================
// button line patterns, pressed lines as ones, and codes
`define BDW_PAT_LEFT 4'h1
`define BDW_PAT_RIGHT 4'h2
`define BDW_PAT_UP 4'h4
`define BDW_PAT_DOWN 4'h8
`define BDW_PAT_CENTRE 4'h3
`define BDW_BTN_NONE 3'h0
`define BDW_BTN_LEFT 3'h1
`define BDW_BTN_RIGHT 3'h2
`define BDW_BTN_UP 3'h3
`define BDW_BTN_DOWN 3'h4
`define BDW_BTN_CENTRE 3'h5
`define BDW_BTN_INVALID 3'h7
// ==========================================
// rates and times
`define BDW_SYS_HZ 40000000
`define BDW_BASE_HZ 20000000
`define BDW_BAUD 115200
`define BDW_SCLK_HALF_NS 100
`define BDW_DEBOUNCE_MS 20
`define BDW_REFRESH_PER_S 10
`endif

// ---- rtl/bdw_button_dac.v ----
// button decoder, display transmitter and serial converter writer
//
// Implementation choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "bdw_regs.vh"

// Function
// - any toggle on four lines raises change
// - decode line pattern into one of five
// - lines active low, zero means pressed
// - debounce timer gives one action per press
// - converter word is exactly sixteen bits
// - first three control bits sent as zero
// - ten sample bits follow, msb first
// - last three filler bits sent as zero
// - select active low, data accepted while low
// - hold converter while display or button serviced
// - at most ten display refreshes per second; limited only in monitor mode
// - display link runs at 115200 baud
// - logic paced by a 20 MHz base
module bdw_button_dac #(
	parameter DEBOUNCE_TICKS = `BDW_DEBOUNCE_MS * (`BDW_BASE_HZ / 1000),
	parameter REFRESH_TICKS = `BDW_BASE_HZ / `BDW_REFRESH_PER_S
) (
	input wire clk_sys,
	input wire sys_rst,
	input wire [4:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	input wire [3:0] btnLinesN,
	output reg dacSelN,
	output reg dacSclk,
	output reg dacDin,
	output reg dispTx,
	output reg irq
);
	localparam BASE_DIV = `BDW_SYS_HZ / `BDW_BASE_HZ;
	localparam BAUD_DIV = `BDW_BASE_HZ / `BDW_BAUD;
	localparam HALF_TICKS = (`BDW_SCLK_HALF_NS * (`BDW_BASE_HZ / 1000000) + 999) / 1000;
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_SHIFT = 2'h1;
	localparam [1:0] ST_END = 2'h2;

	function [2:0] decodeButton;
		input [3:0] pressed;
		begin
			case (pressed)
				4'h0: decodeButton = `BDW_BTN_NONE;
				`BDW_PAT_LEFT: decodeButton = `BDW_BTN_LEFT;
				`BDW_PAT_RIGHT: decodeButton = `BDW_BTN_RIGHT;
				`BDW_PAT_UP: decodeButton = `BDW_BTN_UP;
				`BDW_PAT_DOWN: decodeButton = `BDW_BTN_DOWN;
				`BDW_PAT_CENTRE: decodeButton = `BDW_BTN_CENTRE;
				default: decodeButton = `BDW_BTN_INVALID;
			endcase
		end
	endfunction

	// ==========================================
	// base tick
	reg [7:0] baseCnt_reg;
	reg baseTick_reg;
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			baseCnt_reg <= 8'h00;
			baseTick_reg <= 1'b0;
		end else if (baseCnt_reg == BASE_DIV[7:0] - 8'h01) begin
			baseCnt_reg <= 8'h00;
			baseTick_reg <= 1'b1;
		end else begin
			baseCnt_reg <= baseCnt_reg + 8'h01;
			baseTick_reg <= 1'b0;
		end
	end

	// ==========================================
	// bus slave
	wire wrCommit = avs_write && !avs_waitrequest;
	wire wrSample = wrCommit && avs_address == `BDW_OFS_SAMPLE;
	wire wrDisp = wrCommit && avs_address == `BDW_OFS_DISP;
	reg monitorMode_reg;
	reg [`BDW_EV_W-1:0] irqStatus_reg;
	reg [`BDW_EV_W-1:0] irqEnable_reg;
	reg [9:0] lastSample_reg;
	reg [9:0] pendSample_reg;
	reg pend_reg;
	reg [1:0] dacState_reg;
	reg [2:0] btnCode_reg;
	reg [3:0] syncB_reg;
	reg dbActive_reg;
	reg txBusy_reg;
	reg [31:0] readMux;
	always @* begin
		readMux = 32'h0000_0000;
		case (avs_address)
			`BDW_OFS_CTRL: readMux[`BDW_CTRL_MONITOR] = monitorMode_reg;
			`BDW_OFS_SAMPLE: readMux = {14'h0000, dacState_reg != ST_IDLE, pend_reg, 6'h00, lastSample_reg};
			`BDW_OFS_BUTTON: readMux = {23'h00_0000, dbActive_reg, syncB_reg, 1'b0, btnCode_reg};
			`BDW_OFS_DISP: readMux[0] = txBusy_reg;
			`BDW_OFS_IRQ_STATUS: readMux[`BDW_EV_W-1:0] = irqStatus_reg;
			`BDW_OFS_IRQ_ENABLE: readMux[`BDW_EV_W-1:0] = irqEnable_reg;
			default: readMux = 32'h0000_0000;
		endcase
	end
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
			monitorMode_reg <= 1'b0;
			irqEnable_reg <= {`BDW_EV_W{1'b0}};
		end else begin
			// one wait cycle, answer on the second
			if ((avs_read || avs_write) && avs_waitrequest) begin
				avs_waitrequest <= 1'b0;
				avs_readdata <= avs_read ? readMux : 32'h0000_0000;
			end else begin
				avs_waitrequest <= 1'b1;
			end
			if (wrCommit && avs_address == `BDW_OFS_CTRL)
				monitorMode_reg <= avs_writedata[`BDW_CTRL_MONITOR];
			if (wrCommit && avs_address == `BDW_OFS_IRQ_ENABLE)
				irqEnable_reg <= avs_writedata[`BDW_EV_W-1:0];
		end
	end

	// ==========================================
	// button lines
	reg [3:0] syncA_reg;
	reg [3:0] prev_reg;
	reg [3:0] stable_reg;
	reg [21:0] dbCnt_reg;
	reg evChange_reg;
	reg evPress_reg;
	wire [3:0] pressedNow = ~syncB_reg;
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			syncA_reg <= `BDW_LINES_IDLE;
			syncB_reg <= `BDW_LINES_IDLE;
			prev_reg <= `BDW_LINES_IDLE;
			stable_reg <= `BDW_LINES_IDLE;
			dbCnt_reg <= 22'h00_0000;
			dbActive_reg <= 1'b0;
			btnCode_reg <= `BDW_BTN_NONE;
			evChange_reg <= 1'b0;
			evPress_reg <= 1'b0;
		end else begin
			syncA_reg <= btnLinesN;
			syncB_reg <= syncA_reg;
			prev_reg <= syncB_reg;
			evChange_reg <= syncB_reg != prev_reg;
			evPress_reg <= 1'b0;
			if (syncB_reg != prev_reg) begin
				// any bounce restarts the quiet window
				dbActive_reg <= 1'b1;
				dbCnt_reg <= 22'h00_0000;
			end else if (dbActive_reg && baseTick_reg) begin
				if (dbCnt_reg == DEBOUNCE_TICKS[21:0] - 22'h00_0001) begin
					dbActive_reg <= 1'b0;
					stable_reg <= syncB_reg;
					// only a press from released counts, release gives nothing
					if (stable_reg == `BDW_LINES_IDLE && pressedNow != 4'h0) begin
						btnCode_reg <= decodeButton(pressedNow);
						evPress_reg <= 1'b1;
					end
				end else begin
					dbCnt_reg <= dbCnt_reg + 22'h00_0001;
				end
			end
		end
	end

	// ==========================================
	// display transmitter with refresh limiter
	reg [9:0] txShift_reg;
	reg [3:0] txBit_reg;
	reg [7:0] baudCnt_reg;
	reg [21:0] gapCnt_reg;
	reg evTxDone_reg;
	reg evRefused_reg;
	wire newRefresh = avs_writedata[`BDW_DISP_NEWREF];
	wire gapOk = gapCnt_reg >= REFRESH_TICKS[21:0];
	wire txAccept = wrDisp && !txBusy_reg && (!newRefresh || !monitorMode_reg || gapOk);
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			txBusy_reg <= 1'b0;
			txShift_reg <= 10'h3FF;
			txBit_reg <= 4'h0;
			baudCnt_reg <= 8'h00;
			gapCnt_reg <= REFRESH_TICKS[21:0];
			dispTx <= 1'b1;
			evTxDone_reg <= 1'b0;
			evRefused_reg <= 1'b0;
		end else begin
			evTxDone_reg <= 1'b0;
			evRefused_reg <= wrDisp && !txAccept;
			if (txAccept && newRefresh)
				gapCnt_reg <= 22'h00_0000;
			else if (baseTick_reg && !gapOk)
				gapCnt_reg <= gapCnt_reg + 22'h00_0001;
			if (txAccept) begin
				txBusy_reg <= 1'b1;
				txShift_reg <= {1'b1, avs_writedata[7:0], 1'b0};
				txBit_reg <= 4'h0;
				baudCnt_reg <= 8'h00;
				dispTx <= 1'b0;
			end else if (txBusy_reg && baseTick_reg) begin
				if (baudCnt_reg == BAUD_DIV[7:0] - 8'h01) begin
					baudCnt_reg <= 8'h00;
					if (txBit_reg == `BDW_UART_LAST_BIT) begin
						txBusy_reg <= 1'b0;
						evTxDone_reg <= 1'b1;
						dispTx <= 1'b1;
					end else begin
						txBit_reg <= txBit_reg + 4'h1;
						txShift_reg <= {1'b1, txShift_reg[9:1]};
						dispTx <= txShift_reg[1];
					end
				end else begin
					baudCnt_reg <= baudCnt_reg + 8'h01;
				end
			end
		end
	end

	// ==========================================
	// converter writer
	reg [15:0] dacShift_reg;
	reg [3:0] dacBit_reg;
	reg [7:0] halfCnt_reg;
	reg evDacDone_reg;
	// a word already in flight completes; only new starts are held
	wire serviceHold = txBusy_reg || txAccept || dbActive_reg;
	wire [15:0] dacWord = {`BDW_DAC_CTRL_BITS, pendSample_reg, `BDW_DAC_FILL_BITS};
	wire halfDone = baseTick_reg && halfCnt_reg == HALF_TICKS[7:0] - 8'h01;
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			dacState_reg <= ST_IDLE;
			dacShift_reg <= 16'h0000;
			dacBit_reg <= 4'h0;
			halfCnt_reg <= 8'h00;
			pend_reg <= 1'b0;
			pendSample_reg <= 10'h000;
			lastSample_reg <= 10'h000;
			dacSelN <= 1'b1;
			dacSclk <= 1'b0;
			dacDin <= 1'b0;
			evDacDone_reg <= 1'b0;
		end else begin
			evDacDone_reg <= 1'b0;
			if (baseTick_reg)
				halfCnt_reg <= halfDone ? 8'h00 : halfCnt_reg + 8'h01;
			case (dacState_reg)
				ST_IDLE: begin
					halfCnt_reg <= 8'h00;
					if (pend_reg && !serviceHold) begin
						dacShift_reg <= dacWord;
						dacDin <= dacWord[15];
						dacSelN <= 1'b0;
						dacSclk <= 1'b0;
						dacBit_reg <= 4'h0;
						lastSample_reg <= pendSample_reg;
						pend_reg <= 1'b0;
						dacState_reg <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					if (halfDone) begin
						if (!dacSclk) begin
							dacSclk <= 1'b1;
						end else begin
							dacSclk <= 1'b0;
							if (dacBit_reg == `BDW_DAC_LAST_BIT) begin
								dacState_reg <= ST_END;
							end else begin
								dacBit_reg <= dacBit_reg + 4'h1;
								dacShift_reg <= {dacShift_reg[14:0], 1'b0};
								dacDin <= dacShift_reg[14];
							end
						end
					end
				end
				ST_END: begin
					if (halfDone) begin
						dacSelN <= 1'b1;
						evDacDone_reg <= 1'b1;
						dacState_reg <= ST_IDLE;
					end
				end
				default: dacState_reg <= ST_IDLE;
			endcase
			// a new sample overwrites one still waiting
			if (wrSample) begin
				pendSample_reg <= avs_writedata[9:0];
				pend_reg <= 1'b1;
			end
		end
	end

	// ==========================================
	// interrupt status, enable and clear
	wire [`BDW_EV_W-1:0] events = {evTxDone_reg, evRefused_reg, evDacDone_reg, evPress_reg, evChange_reg};
	wire [`BDW_EV_W-1:0] clrMask = (wrCommit && avs_address == `BDW_OFS_IRQ_CLEAR) ?
		avs_writedata[`BDW_EV_W-1:0] : {`BDW_EV_W{1'b0}};
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			irqStatus_reg <= {`BDW_EV_W{1'b0}};
			irq <= 1'b0;
		end else begin
			// set wins over clear
			irqStatus_reg <= (irqStatus_reg & ~clrMask) | events;
			irq <= |(irqStatus_reg & irqEnable_reg);
		end
	end
endmodule
`default_nettype wire

// ---- verif/bdw_button_dac_sva.sv ----
// assertions on the bus handshake and the converter word
`timescale 1ns/1ps
`default_nettype none
module bdw_button_dac_sva (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic [3:0] btnLinesN,
	input wire logic dacSelN,
	input wire logic dacSclk,
	input wire logic dacDin,
	input wire logic dispTx
);
	logic [4:0] edgeCnt_reg;
	logic [15:0] word_reg;
	logic sclkQ_reg;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// ==========================================
	// word capture as the converter sees it
	always_ff @(posedge clk_sys) begin
		sclkQ_reg <= dacSclk;
		if (sys_rst || dacSelN) begin
			edgeCnt_reg <= 5'h00;
		end else if (dacSclk && !sclkQ_reg) begin
			edgeCnt_reg <= edgeCnt_reg + 5'h01;
			word_reg <= {word_reg[14:0], dacDin};
		end
	end
	// ==========================================
	// properties
	a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("wait low too long");
	a_sclk_idle: assert property (dacSelN |-> !dacSclk)
		else $error("serial clock outside frame");
	a_din_steady: assert property (dacSclk |-> $stable(dacDin))
		else $error("data moved with clock high");
	a_word_count: assert property ($rose(dacSelN) |-> edgeCnt_reg == 5'h10)
		else $error("word not sixteen bits");
	a_word_frame: assert property ($rose(dacSelN) |-> word_reg[15:13] == 3'h0 && word_reg[2:0] == 3'h0)
		else $error("control or filler bits set");
	a_sclk_half: assert property ($rose(dacSclk) |-> dacSclk [*4] ##1 !dacSclk)
		else $error("clock high phase wrong");
	a_hold_tx: assert property (!dispTx |-> !$fell(dacSelN))
		else $error("word started during display send");
	a_hold_button: assert property ($changed(btnLinesN) |-> ##5 (!$fell(dacSelN)) [*8])
		else $error("word started during button service");
	c_word: cover property ($rose(dacSelN));
	c_press: cover property ($fell(btnLinesN[0]));
	c_disp: cover property ($fell(dispTx));
endmodule
`default_nettype wire

// ---- verif/bdw_dac_model.sv ----
// behavioural serial converter on the far side of the select line
`timescale 1ns/1ps
`default_nettype none
module bdw_dac_model (
	input wire logic dacSelN,
	input wire logic dacSclk,
	input wire logic dacDin,
	output logic [9:0] dacValue,
	output logic [2:0] dacCtrl,
	output logic [2:0] dacFill,
	output logic [15:0] nWords
);
	logic [15:0] shift;
	int nBits;
	initial begin
		dacValue = 10'h000;
		dacCtrl = 3'h0;
		dacFill = 3'h0;
		nWords = 16'h0000;
		shift = 16'h0000;
		nBits = 0;
	end
	always @(posedge dacSclk) begin
		if (!dacSelN) begin
			shift = {shift[14:0], dacDin};
			nBits++;
		end
	end
	always @(negedge dacSelN) nBits = 0;
	// a partial word is dropped, as the real part would
	always @(posedge dacSelN) begin
		if (nBits == 16) begin
			{dacCtrl, dacValue, dacFill} = shift;
			nWords++;
		end
	end
endmodule
`default_nettype wire

// ---- verif/test_bdw_button_dac.sv ----
// self-checking bench of the button decoder and converter writer
`timescale 1ns/1ps
`default_nettype none
`include "bdw_regs.vh"
`define CHK(a,b) begin comparisons++; if ((a) !== (b)) begin n_fail++; $display("unexpected %0t got %0h want %0h", $time, (a), (b)); end end
module test_bdw_button_dac;
	logic clk_sys = 0, sys_rst = 1, avs_read = 0, avs_write = 0;
	logic [4:0] avs_address = 5'h00;
	logic [31:0] avs_writedata = 32'h0000_0000, rd;
	logic [3:0] btnLinesN = 4'hF;
	wire [31:0] avs_readdata;
	wire avs_waitrequest, dacSelN, dacSclk, dacDin, dispTx, irq;
	wire [9:0] dacValue;
	wire [2:0] dacCtrl, dacFill;
	wire [15:0] nWords;
	int n_fail = 0, comparisons = 0;
	bdw_button_dac #(.DEBOUNCE_TICKS(50), .REFRESH_TICKS(4000)) u_bdw_button_dac (.clk_sys(clk_sys),
		.sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.btnLinesN(btnLinesN), .dacSelN(dacSelN), .dacSclk(dacSclk), .dacDin(dacDin), .dispTx(dispTx), .irq(irq));
	bdw_dac_model u_bdw_dac_model (.dacSelN(dacSelN), .dacSclk(dacSclk), .dacDin(dacDin), .dacValue(dacValue),
		.dacCtrl(dacCtrl), .dacFill(dacFill), .nWords(nWords));
	initial forever #12.5 clk_sys = ~clk_sys;
	task automatic finish_test;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// ==========================================
	// bus and wait helpers
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !w;
		avs_write <= w;
		for (i = 0; i < 50; i++) begin
			@(posedge clk_sys);
			if (avs_waitrequest === 1'b0) break;
		end
		if (i == 50) begin
			n_fail++;
			$display("unexpected %0t bus timeout", $time);
			finish_test();
		end
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic wait_words(input int n);
		int i;
		for (i = 0; i < 6000 && nWords != n; i++) @(posedge clk_sys);
		if (i == 6000) begin
			n_fail++;
			$display("unexpected %0t word timeout", $time);
			finish_test();
		end
	endtask
	// bounce shorter than the debounce time, then settle at v
	task automatic settle(input logic [3:0] v, input logic [3:0] o);
		repeat (3) begin
			btnLinesN <= v;
			repeat (9) @(posedge clk_sys);
			btnLinesN <= o;
			repeat (9) @(posedge clk_sys);
		end
		btnLinesN <= v;
		repeat (200) @(posedge clk_sys);
	endtask
	// ==========================================
	// scenarios
	task automatic t_regs;
		bus(0, `BDW_OFS_CTRL, 32'h0000_0000);
		`CHK(rd, 32'h0000_0000)
		bus(1, `BDW_OFS_IRQ_ENABLE, 32'h0000_001F);
		bus(0, `BDW_OFS_IRQ_ENABLE, 32'h0000_0000);
		`CHK(rd[4:0], 5'h1F)
		bus(0, 5'h1C, 32'h0000_0000);
		`CHK(rd, 32'h0000_0000)
	endtask
	task automatic t_dac;
		logic [9:0] v [4] = '{10'h3FF, 10'h2AA, 10'h155, 10'h001};
		for (int k = 0; k < 4; k++) begin
			bus(1, `BDW_OFS_SAMPLE, {22'h00_0000, v[k]});
			wait_words(k + 1);
			`CHK(dacValue, v[k])
			`CHK({dacCtrl, dacFill}, 6'h00)
		end
	endtask
	task automatic t_button;
		logic [3:0] pat [5] = '{`BDW_PAT_LEFT, `BDW_PAT_RIGHT, `BDW_PAT_UP, `BDW_PAT_DOWN, `BDW_PAT_CENTRE};
		logic [2:0] code [5] = '{`BDW_BTN_LEFT, `BDW_BTN_RIGHT, `BDW_BTN_UP, `BDW_BTN_DOWN, `BDW_BTN_CENTRE};
		// a bouncing button holds back a queued word
		btnLinesN <= 4'hE;
		bus(1, `BDW_OFS_SAMPLE, 32'h0000_0133);
		bus(0, `BDW_OFS_SAMPLE, 32'h0000_0000);
		`CHK(rd[17:16], 2'b01)
		`CHK(dacValue, 10'h001)
		settle(4'hF, 4'hE);
		wait_words(5);
		`CHK(dacValue, 10'h133)
		for (int k = 0; k < 5; k++) begin
			bus(1, `BDW_OFS_IRQ_CLEAR, 32'h0000_001F);
			settle(~pat[k], 4'hF);
			bus(0, `BDW_OFS_BUTTON, 32'h0000_0000);
			`CHK(rd[2:0], code[k])
			bus(0, `BDW_OFS_IRQ_STATUS, 32'h0000_0000);
			`CHK(rd[1:0], 2'b11)
			`CHK(irq, 1'b1)
			bus(1, `BDW_OFS_IRQ_CLEAR, 32'h0000_001F);
			settle(4'hF, ~pat[k]);
			bus(0, `BDW_OFS_IRQ_STATUS, 32'h0000_0000);
			`CHK(rd[1:0], 2'b01)
			bus(1, `BDW_OFS_IRQ_ENABLE, 32'h0000_0000);
			repeat (3) @(posedge clk_sys);
			`CHK(irq, 1'b0)
			bus(1, `BDW_OFS_IRQ_ENABLE, 32'h0000_001F);
		end
	endtask
	task automatic t_disp;
		int n;
		int w;
		bus(1, `BDW_OFS_CTRL, 32'h0000_0001);
		bus(1, `BDW_OFS_DISP, 32'h0000_0101);
		for (n = 0; n < 100 && dispTx !== 1'b0; n++) @(posedge clk_sys);
		// start bit is not tick aligned; time the first data bit, a one
		for (n = 0; n < 1000 && dispTx === 1'b0; n++) @(posedge clk_sys);
		for (w = 0; w < 1000 && dispTx === 1'b1; w++) @(posedge clk_sys);
		`CHK(w, 346)
		bus(1, `BDW_OFS_SAMPLE, 32'h0000_02A5);
		bus(0, `BDW_OFS_SAMPLE, 32'h0000_0000);
		`CHK(rd[17:16], 2'b01)
		wait_words(6);
		`CHK(dacValue, 10'h2A5)
		bus(1, `BDW_OFS_IRQ_CLEAR, 32'h0000_001F);
		bus(1, `BDW_OFS_DISP, 32'h0000_0101);
		bus(0, `BDW_OFS_IRQ_STATUS, 32'h0000_0000);
		`CHK(rd[3], 1'b1)
		bus(1, `BDW_OFS_CTRL, 32'h0000_0000);
		bus(1, `BDW_OFS_IRQ_CLEAR, 32'h0000_001F);
		bus(1, `BDW_OFS_DISP, 32'h0000_0101);
		bus(0, `BDW_OFS_IRQ_STATUS, 32'h0000_0000);
		`CHK(rd[3], 1'b0)
	endtask
	initial begin
		repeat (20) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		t_regs();
		t_dac();
		t_button();
		t_disp();
		finish_test();
	end
endmodule
bind bdw_button_dac bdw_button_dac_sva u_bdw_button_dac_sva (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .btnLinesN(btnLinesN),
	.dacSelN(dacSelN), .dacSclk(dacSclk), .dacDin(dacDin), .dispTx(dispTx));
`default_nettype wire
